// ### core/lvdw_top.sv
// Low-voltage detector control, interrupt flags, service and wake-up logic
//
// Added by the designer: the address map and the plain strobed port.
`timescale 1ns/1ps
`default_nettype none
`include "lvdw_defines.svh"

module lvdw_top import lvdw_pkg::*; #(
   parameter int unsigned LVD_DELAY_CYC = `LVDW_IRQ_DLY_CYC,
   parameter int unsigned LV_GROUP      = 0
) (
   input  wire logic       i_clk,
   input  wire logic       i_rst_b,
   input  wire lvdw_bus_t  i_bus,
   output logic [7:0]      o_rdata,
   input  wire logic       i_lv_cmp,
   output logic            o_lv_enable,
   output logic [2:0]      o_lv_level,
   input  wire logic       i_hall_evt,
   input  wire logic [7:0] i_grp_evt,
   input  wire logic       i_sleep,
   output logic            o_wake,
   output logic            o_vec_req,
   input  wire logic       i_irq_ack,
   output logic            o_push_pc,
   output logic [3:0]      o_vec_idx,
   input  wire logic       i_return_from_interrupt,
   input  wire logic       i_return_from_subroutine
);

   default clocking cb @(posedge i_clk); endclocking
   default disable iff (!i_rst_b);

   function automatic logic hit(input lvdw_bus_t b, input logic [3:0] off);
      hit = (b.addr == off);
   endfunction

   // Lowest index wins: hall first, then group zero upward
   function automatic logic [3:0] pick(input logic [8:0] p);
      pick = 4'h0;
      for (int i = 8; i >= 0; i--) begin
         if (p[i]) begin
            pick = 4'(i);
         end
      end
   endfunction

   logic       cmp_s;
   logic       lv_flag;
   logic       lv_fire;
   logic [2:0] sel_r;
   logic       en_r;
   logic       global_irq_enable_r;
   logic       lvie_r;
   logic       hale_r;
   logic       lvf_r;
   logic       hall_group_flag_r;
   logic [7:0] grpf_r;
   logic [7:0] grpe_r;
   logic [9:0] prev_r;
   logic [9:0] wcause_r;
   logic       wake_r;
   logic [7:0] rdata_r;
   logic [3:0] vec_idx_r;
   lvdw_svc_t  svc_r;
   lvdw_svc_t  svc_nxt;
   logic [8:0] pend;
   logic [8:0] svc_clr;
   logic [9:0] all_flags;
   logic [9:0] rises;
   logic       ack_take;
   logic       wr_ctrl;
   logic       wr_irqc;
   logic       wr_flags;
   logic       wr_grpf;
   logic       wr_grpe;
   logic       wr_wcause;
   logic [7:0] rd_nxt;

   assign wr_ctrl   = i_bus.wr && hit(i_bus, `LVDW_OFF_CTRL);
   assign wr_irqc   = i_bus.wr && hit(i_bus, `LVDW_OFF_IRQC);
   assign wr_flags  = i_bus.wr && hit(i_bus, `LVDW_OFF_FLAGS);
   assign wr_grpf   = i_bus.wr && hit(i_bus, `LVDW_OFF_GRPF);
   assign wr_grpe   = i_bus.wr && hit(i_bus, `LVDW_OFF_GRPE);
   assign wr_wcause = i_bus.wr && hit(i_bus, `LVDW_OFF_WCAUSE);

   // Detector front end
   lvdw_sync2 u_sync (
      .i_clk   (i_clk),
      .i_rst_b (i_rst_b),
      .i_async (i_lv_cmp),
      .o_sync  (cmp_s)
   );

   // A switched-off detector reports no low voltage
   assign lv_flag = en_r & cmp_s;

   lvdw_delay #(
      .N (LVD_DELAY_CYC)
   ) u_delay (
      .i_clk   (i_clk),
      .i_rst_b (i_rst_b),
      .i_level (lv_flag),
      .o_fire  (lv_fire)
   );

   // Sleep does not gate the enable to the analog side
   assign o_lv_enable = en_r;
   assign o_lv_level  = sel_r;

   always_ff @(posedge i_clk or negedge i_rst_b) begin
      if (!i_rst_b) begin
         sel_r <= 3'(`LVDW_RST_CTRL);
         en_r  <= 1'b0;
      end else if (wr_ctrl) begin
         sel_r <= i_bus.wdata[`LVDW_CTRL_SEL_MSB:`LVDW_CTRL_SEL_LSB];
         en_r  <= i_bus.wdata[`LVDW_CTRL_EN_BIT];
      end
   end

   // Global enable: cleared on entry, set by return from interrupt
   always_ff @(posedge i_clk or negedge i_rst_b) begin
      if (!i_rst_b) begin
         global_irq_enable_r <= 1'b0;
         lvie_r              <= 1'b0;
         hale_r              <= 1'b0;
      end else begin
         if (ack_take) begin
            global_irq_enable_r <= 1'b0;
         end else if (i_return_from_interrupt) begin
            global_irq_enable_r <= 1'b1;
         end else if (wr_irqc) begin
            global_irq_enable_r <= i_bus.wdata[`LVDW_IRQC_GIE_BIT];
         end
         // Plain return has no path into the enable
         if (wr_irqc) begin
            lvie_r <= i_bus.wdata[`LVDW_IRQC_LVIE_BIT];
            hale_r <= i_bus.wdata[`LVDW_IRQC_HALE_BIT];
         end
      end
   end

   // Source flags: hardware set beats any clear in the same cycle
   always_ff @(posedge i_clk or negedge i_rst_b) begin
      if (!i_rst_b) begin
         lvf_r             <= 1'b0;
         hall_group_flag_r <= 1'b0;
      end else begin
         if (lv_fire) begin
            lvf_r <= 1'b1;
         end else if (wr_flags) begin
            lvf_r <= i_bus.wdata[`LVDW_FLG_LV_BIT];
         end
         if (i_hall_evt) begin
            hall_group_flag_r <= 1'b1;
         end else if (svc_clr[0]) begin
            hall_group_flag_r <= 1'b0;
         end else if (wr_flags) begin
            hall_group_flag_r <= i_bus.wdata[`LVDW_FLG_HALL_BIT];
         end
      end
   end

   // Grouped flags; the low-voltage source feeds one group
   for (genvar k = 0; k < 8; k++) begin : g_grp
      logic set_k;
      if (k == LV_GROUP) begin : g_lv
         assign set_k = i_grp_evt[k] | (lv_fire & lvie_r);
      end else begin : g_oth
         assign set_k = i_grp_evt[k];
      end
      always_ff @(posedge i_clk or negedge i_rst_b) begin
         if (!i_rst_b) begin
            grpf_r[k] <= 1'b0;
         end else if (set_k) begin
            grpf_r[k] <= 1'b1;
         end else if (svc_clr[k+1]) begin
            grpf_r[k] <= 1'b0;
         end else if (wr_grpf) begin
            grpf_r[k] <= i_bus.wdata[k];
         end
      end
   end

   always_ff @(posedge i_clk or negedge i_rst_b) begin
      if (!i_rst_b) begin
         grpe_r <= `LVDW_RST_GRP;
      end else if (wr_grpe) begin
         grpe_r <= i_bus.wdata;
      end
   end

   // Service: request, acknowledge, then one push cycle
   assign pend      = {grpf_r & grpe_r, hall_group_flag_r & hale_r};
   assign o_vec_req = global_irq_enable_r && (|pend) && (svc_r == LVDW_SVC_IDLE);
   assign ack_take  = i_irq_ack && o_vec_req;

   always_comb begin
      svc_clr = 9'h000;
      if (ack_take) begin
         svc_clr[pick(pend)] = 1'b1;
      end
   end

   always_comb begin
      case (svc_r)
         LVDW_SVC_IDLE: svc_nxt = ack_take ? LVDW_SVC_PUSH : LVDW_SVC_IDLE;
         LVDW_SVC_PUSH: svc_nxt = LVDW_SVC_IDLE;
         default:       svc_nxt = LVDW_SVC_IDLE;
      endcase
   end

   always_ff @(posedge i_clk or negedge i_rst_b) begin
      if (!i_rst_b) begin
         svc_r     <= LVDW_SVC_IDLE;
         vec_idx_r <= 4'h0;
      end else begin
         svc_r <= svc_nxt;
         if (ack_take) begin
            vec_idx_r <= pick(pend);
         end
      end
   end

   // Only the return address goes on the stack
   assign o_push_pc = (svc_r == LVDW_SVC_PUSH);
   assign o_vec_idx = vec_idx_r;

   // Wake-up: any flag edge, enables play no part
   assign all_flags = {grpf_r, hall_group_flag_r, lvf_r};
   assign rises     = all_flags & ~prev_r;

   always_ff @(posedge i_clk or negedge i_rst_b) begin
      if (!i_rst_b) begin
         prev_r   <= 10'h000;
         wake_r   <= 1'b0;
         wcause_r <= 10'h000;
      end else begin
         prev_r <= all_flags;
         wake_r <= i_sleep && (|rises);
         if (i_sleep && (|rises)) begin
            wcause_r <= wcause_r | rises;
         end else if (wr_wcause) begin
            wcause_r <= 10'h000;
         end
      end
   end

   assign o_wake = wake_r;

   // Read port: data only in the cycle after the strobe
   always_comb begin
      rd_nxt = 8'h00;
      if (hit(i_bus, `LVDW_OFF_CTRL)) begin
         rd_nxt = {2'b00, lv_flag, en_r, 1'b0, sel_r};
      end else if (hit(i_bus, `LVDW_OFF_IRQC)) begin
         rd_nxt = {5'h00, hale_r, lvie_r, global_irq_enable_r};
      end else if (hit(i_bus, `LVDW_OFF_FLAGS)) begin
         rd_nxt = {6'h00, hall_group_flag_r, lvf_r};
      end else if (hit(i_bus, `LVDW_OFF_GRPF)) begin
         rd_nxt = grpf_r;
      end else if (hit(i_bus, `LVDW_OFF_GRPE)) begin
         rd_nxt = grpe_r;
      end else if (hit(i_bus, `LVDW_OFF_WCAUSE)) begin
         rd_nxt = wcause_r[7:0];
      end
   end

   always_ff @(posedge i_clk or negedge i_rst_b) begin
      if (!i_rst_b) begin
         rdata_r <= 8'h00;
      end else begin
         rdata_r <= i_bus.rd ? rd_nxt : 8'h00;
      end
   end

   assign o_rdata = rdata_r;

   // Checks
   sequence s_ack;
      ack_take;
   endsequence

   sequence s_push_once;
      o_push_pc && !global_irq_enable_r ##1 !o_push_pc;
   endsequence

   a_push_after_ack: assert property (s_ack |=> s_push_once)
      else $error("entry did not give exactly one push");

   a_flag_follow: assert property (en_r && $past(en_r) && $past(en_r, 2)
      |-> lv_flag == $past(i_lv_cmp, 2))
      else $error("detector flag does not track comparator");

   a_wake_on_rise: assert property (i_sleep && $rose(lvf_r) |=> o_wake)
      else $error("flag rise in sleep gave no wake");

   a_wake_cause: assert property (o_wake |-> $past(i_sleep) && |($past(rises)))
      else $error("wake without a flag edge in sleep");

   a_flag_sticky: assert property (lvf_r && !wr_flags |=> lvf_r)
      else $error("interrupt flag dropped without software");

   a_irq_return_sets: assert property (i_return_from_interrupt && !ack_take
      |=> global_irq_enable_r)
      else $error("return from interrupt left enable low");

   a_sub_return_keeps: assert property (i_return_from_subroutine
      && !i_return_from_interrupt && !ack_take && !wr_irqc
      |=> global_irq_enable_r == $past(global_irq_enable_r))
      else $error("subroutine return altered enable");

   a_unimpl_zero: assert property (i_bus.rd && hit(i_bus, `LVDW_OFF_CTRL)
      |=> o_rdata[7:6] == 2'b00 && !o_rdata[3] && o_rdata[2:0] == $past(sel_r))
      else $error("control readback wrong");

   a_vec_gate: assert property (o_vec_req |-> global_irq_enable_r
      && ((hall_group_flag_r && hale_r) || |(grpf_r & grpe_r)))
      else $error("vector requested without enables");

   // The fire pulse lags the level by one cycle, so the level is checked two back
   a_lvf_after_delay: assert property ($rose(lvf_r) && !$past(wr_flags)
      |-> $past(lv_flag, 2) && $past(lv_fire))
      else $error("interrupt flag set without delayed level");

endmodule
`default_nettype wire

// ### inc/lvdw_defines.svh
// Register offsets, field positions, reset values and timing counts of the low-voltage block
`ifndef LVDW_DEFINES_SVH
`define LVDW_DEFINES_SVH

`define LVDW_OFF_CTRL      4'h0
`define LVDW_OFF_IRQC      4'h1
`define LVDW_OFF_FLAGS     4'h2
`define LVDW_OFF_GRPF      4'h3
`define LVDW_OFF_GRPE      4'h4
`define LVDW_OFF_WCAUSE    4'h5

`define LVDW_CTRL_SEL_LSB  0
`define LVDW_CTRL_SEL_MSB  2
`define LVDW_CTRL_EN_BIT   4
`define LVDW_CTRL_OUT_BIT  5

`define LVDW_IRQC_GIE_BIT  0
`define LVDW_IRQC_LVIE_BIT 1
`define LVDW_IRQC_HALE_BIT 2

`define LVDW_FLG_LV_BIT    0
`define LVDW_FLG_HALL_BIT  1

`define LVDW_RST_CTRL      8'h00
`define LVDW_RST_IRQC      8'h00
`define LVDW_RST_GRP       8'h00

`define LVDW_CLK_NS        50
`define LVDW_IRQ_DLY_NS    15000
`define LVDW_IRQ_DLY_CYC   ((`LVDW_IRQ_DLY_NS + `LVDW_CLK_NS - 1) / `LVDW_CLK_NS)

`endif

// ### inc/lvdw_pkg.sv
// Types shared by the low-voltage detect and wake-up block
package lvdw_pkg;

   typedef struct packed {
      logic [3:0] addr;
      logic [7:0] wdata;
      logic       wr;
      logic       rd;
   } lvdw_bus_t;

   typedef enum logic [1:0] {
      LVDW_SVC_IDLE = 2'b01,
      LVDW_SVC_PUSH = 2'b10
   } lvdw_svc_t;

endpackage

// ### core/lvdw_sync2.sv
// Two flip-flop synchroniser for the asynchronous comparator level
`timescale 1ns/1ps
`default_nettype none

module lvdw_sync2 (
   input  wire logic i_clk,
   input  wire logic i_rst_b,
   input  wire logic i_async,
   output logic      o_sync
);

   logic meta_r;
   logic sync_r;

   // First stage is read by the second stage only
   always_ff @(posedge i_clk or negedge i_rst_b) begin
      if (!i_rst_b) begin
         meta_r <= 1'b0;
         sync_r <= 1'b0;
      end else begin
         meta_r <= i_async;
         sync_r <= meta_r;
      end
   end

   assign o_sync = sync_r;

endmodule
`default_nettype wire

// ### core/lvdw_delay.sv
// Fires one pulse once a level has been high for a fixed number of cycles
`timescale 1ns/1ps
`default_nettype none

module lvdw_delay #(
   parameter int unsigned N = 300
) (
   input  wire logic i_clk,
   input  wire logic i_rst_b,
   input  wire logic i_level,
   output logic      o_fire
);

   localparam int unsigned CW = $clog2(N + 1);

   logic [CW-1:0] cnt_r;
   logic          done_r;
   logic          fire_r;

   // A glitch low restarts the wait; one pulse per high period
   always_ff @(posedge i_clk or negedge i_rst_b) begin
      if (!i_rst_b) begin
         cnt_r  <= '0;
         done_r <= 1'b0;
         fire_r <= 1'b0;
      end else if (!i_level) begin
         cnt_r  <= '0;
         done_r <= 1'b0;
         fire_r <= 1'b0;
      end else if (!done_r && cnt_r == CW'(N - 1)) begin
         done_r <= 1'b1;
         fire_r <= 1'b1;
      end else begin
         fire_r <= 1'b0;
         if (!done_r) begin
            cnt_r <= cnt_r + CW'(1);
         end
      end
   end

   assign o_fire = fire_r;

   a_fire_level: assert property (@(posedge i_clk) disable iff (!i_rst_b)
      o_fire |-> $past(i_level) && !$past(o_fire))
      else $error("delay pulse without a held level");

endmodule
`default_nettype wire

// ### bench/lvdw_tb.sv
// Self-checking bench for the low-voltage detect and wake-up block
`timescale 1ns/1ps
`default_nettype none

module testbench import lvdw_pkg::*;;
   localparam int N = 4;
   logic       i_clk;
   logic       i_rst_b;
   lvdw_bus_t  i_bus;
   logic [7:0] o_rdata;
   logic       i_lv_cmp;
   logic       o_lv_enable;
   logic [2:0] o_lv_level;
   logic       i_hall_evt;
   logic [7:0] i_grp_evt;
   logic       i_sleep;
   logic       o_wake;
   logic       o_vec_req;
   logic       i_irq_ack;
   logic       o_push_pc;
   logic [3:0] o_vec_idx;
   logic       i_return_from_interrupt;
   logic       i_return_from_subroutine;
   int         err_count;
   int         num_checks;
   int         c;

   lvdw_top #(.LVD_DELAY_CYC(N), .LV_GROUP(0)) dut (
      .i_clk(i_clk), .i_rst_b(i_rst_b), .i_bus(i_bus), .o_rdata(o_rdata),
      .i_lv_cmp(i_lv_cmp), .o_lv_enable(o_lv_enable), .o_lv_level(o_lv_level),
      .i_hall_evt(i_hall_evt), .i_grp_evt(i_grp_evt), .i_sleep(i_sleep),
      .o_wake(o_wake), .o_vec_req(o_vec_req), .i_irq_ack(i_irq_ack),
      .o_push_pc(o_push_pc), .o_vec_idx(o_vec_idx),
      .i_return_from_interrupt(i_return_from_interrupt),
      .i_return_from_subroutine(i_return_from_subroutine)
   );

   always #25 i_clk = ~i_clk;

   task automatic results();
      $display("Checks made %0d, mismatches %0d", num_checks, err_count);
      if (err_count == 0 && num_checks > 0) begin
         $display("All checks passed");
      end else begin
         $display("Checks failed");
      end
      $finish;
   endtask

   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      num_checks++;
      if (got !== exp) begin
         err_count++;
         $display("Error at %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   task automatic tick(input int n);
      repeat (n) @(posedge i_clk);
   endtask

   task automatic wr(input logic [3:0] a, input logic [7:0] d);
      @(posedge i_clk);
      i_bus <= '{a, d, 1'b1, 1'b0};
      @(posedge i_clk);
      i_bus <= '0;
   endtask

   // Read data are only valid in the cycle after the strobe
   task automatic rd(input logic [3:0] a, input logic [7:0] e);
      @(posedge i_clk);
      i_bus <= '{a, 8'h00, 1'b0, 1'b1};
      @(posedge i_clk);
      i_bus <= '0;
      #1 chk(o_rdata, e);
   endtask

   // Returns the cycle count at the wake pulse; if none came, 0, or the run ends when one was required
   task automatic wake(input int maxc, input bit must, output int n);
      n = 0;
      for (int k = 1; k <= maxc && n == 0; k++) begin
         @(posedge i_clk);
         #1 if (o_wake === 1'b1) n = k;
      end
      if (must && n == 0) begin
         err_count++;
         $display("Error at %0t: got %h expected %h", $time, 1'b0, 1'b1);
         results();
      end
   endtask

   task automatic svc(input logic [3:0] idx);
      #1 chk(o_vec_req, 8'h01);
      @(posedge i_clk);
      i_irq_ack <= 1'b1;
      @(posedge i_clk);
      i_irq_ack <= 1'b0;
      #1 chk(o_push_pc, 8'h01);
      chk(o_vec_idx, idx);
      chk(o_vec_req, 8'h00);
      @(posedge i_clk);
      #1 chk(o_push_pc, 8'h00);
   endtask

   initial begin
      i_clk = 1'b0;
      i_rst_b = 1'b0;
      i_bus = '0;
      {i_lv_cmp, i_hall_evt, i_sleep, i_irq_ack} = '0;
      {i_return_from_interrupt, i_return_from_subroutine} = '0;
      i_grp_evt = 8'h00;
      err_count = 0;
      num_checks = 0;
      tick(12);
      i_rst_b <= 1'b1;
      rd(4'h0, 8'h00);
      rd(4'h1, 8'h00);
      wr(4'hF, 8'hFF);
      rd(4'hF, 8'h00);
      for (int k = 0; k < 8; k++) begin
         wr(4'h0, 8'hC8 | k[7:0]);
         rd(4'h0, k[7:0]);
         chk(o_lv_level, k[7:0]);
         chk(o_lv_enable, 8'h00);
      end
      wr(4'h0, 8'hFF);
      rd(4'h0, 8'h17);
      chk(o_lv_enable, 8'h01);
      @(posedge i_clk) i_lv_cmp <= 1'b1;
      tick(2);
      rd(4'h0, 8'h37);
      wr(4'h0, 8'h07);
      rd(4'h0, 8'h07);
      @(posedge i_clk) i_lv_cmp <= 1'b0;
      wr(4'h0, 8'h17);
      tick(3);
      rd(4'h0, 8'h17);
      wr(4'h2, 8'h00);
      wr(4'h3, 8'h00);
      // A low spell shorter than the delay must not raise the flag
      wr(4'h1, 8'h02);
      i_sleep <= 1'b1;
      @(posedge i_clk) i_lv_cmp <= 1'b1;
      tick(N - 2);
      i_lv_cmp <= 1'b0;
      wake(12, 1'b0, c);
      chk(c[7:0], 8'h00);
      rd(4'h2, 8'h00);
      @(posedge i_clk) i_lv_cmp <= 1'b1;
      wake(N + 8, 1'b1, c);
      chk(c[7:0], 8'(N + 4));
      rd(4'h2, 8'h01);
      rd(4'h3, 8'h01);
      rd(4'h0, 8'h37);
      rd(4'h5, 8'h05);
      @(posedge i_clk) i_lv_cmp <= 1'b0;
      wr(4'h2, 8'h00);
      wr(4'h3, 8'h00);
      wr(4'h1, 8'h00);
      @(posedge i_clk) i_hall_evt <= 1'b1;
      @(posedge i_clk) i_hall_evt <= 1'b0;
      wake(4, 1'b1, c);
      tick(20);
      rd(4'h2, 8'h02);
      @(posedge i_clk) i_hall_evt <= 1'b1;
      @(posedge i_clk) i_hall_evt <= 1'b0;
      wake(6, 1'b0, c);
      chk(c[7:0], 8'h00);
      for (int k = 0; k < 8; k++) begin
         @(posedge i_clk) i_grp_evt <= 8'h01 << k;
         @(posedge i_clk) i_grp_evt <= 8'h00;
         wake(4, 1'b1, c);
      end
      rd(4'h3, 8'hFF);
      rd(4'h5, 8'hFF);
      wr(4'h5, 8'h00);
      i_sleep <= 1'b0;
      // Hall outranks group two; service clears only the hall flag
      wr(4'h4, 8'hFF);
      wr(4'h3, 8'h04);
      wr(4'h1, 8'h07);
      svc(4'h0);
      rd(4'h2, 8'h00);
      rd(4'h3, 8'h04);
      rd(4'h1, 8'h06);
      @(posedge i_clk) i_return_from_subroutine <= 1'b1;
      @(posedge i_clk) i_return_from_subroutine <= 1'b0;
      rd(4'h1, 8'h06);
      #1 chk(o_vec_req, 8'h00);
      @(posedge i_clk) i_return_from_interrupt <= 1'b1;
      @(posedge i_clk) i_return_from_interrupt <= 1'b0;
      rd(4'h1, 8'h07);
      svc(4'h3);
      rd(4'h3, 8'h00);
      @(posedge i_clk) i_return_from_interrupt <= 1'b1;
      @(posedge i_clk) i_return_from_interrupt <= 1'b0;
      wr(4'h2, 8'h01);
      wr(4'h3, 8'h01);
      wr(4'h4, 8'hFE);
      #1 chk(o_vec_req, 8'h00);
      wr(4'h4, 8'hFF);
      svc(4'h1);
      rd(4'h2, 8'h01);
      rd(4'h3, 8'h00);
      rd(4'h5, 8'h00);
      results();
   end
endmodule

`default_nettype wire
